// File: serial_pkg.sv
// Purpose: shared constants and types for the serial receive/arbiter block
// Assumes: 8-bit register port, one clock
// Notes:   register offsets are local choices
package serial_pkg;
  localparam logic [2:0] OFF_STATUS_ONE  = 3'h0;
  localparam logic [2:0] OFF_STATUS_TWO  = 3'h1;
  localparam logic [2:0] OFF_CONTROL_ONE = 3'h2;
  localparam logic [2:0] OFF_CONTROL_TWO = 3'h3;
  localparam logic [2:0] OFF_CONTROL_THR = 3'h4;
  localparam logic [2:0] OFF_DATA        = 3'h5;
  localparam logic [2:0] OFF_ARB_CTL     = 3'h6;
  localparam logic [2:0] OFF_ARB_CNT     = 3'h7;
  // Status one fields
  localparam int FLD_RX_FULL  = 5;
  localparam int FLD_NOISE    = 2;
  localparam int FLD_FRAMING  = 1;
  localparam int FLD_PARITY   = 0;
  // Status two fields
  localparam int FLD_BREAK    = 1;
  localparam int FLD_RX_BUSY  = 0;
  // Control one fields
  localparam int FLD_NINE_BIT = 4;
  localparam int FLD_TX_INV   = 5;
  // Control two fields
  localparam int FLD_RX_IE    = 5;
  localparam int FLD_TX_EN    = 3;
  localparam int FLD_RX_EN    = 2;
  localparam int FLD_SEND_BRK = 0;
  // Control three fields
  localparam int FLD_NINTH    = 7;
  // Arbiter control fields
  localparam int FLD_AM_HIGH  = 7;
  localparam int FLD_AM_LOW   = 6;
  localparam int FLD_LOST     = 5;
  localparam int FLD_ACLK     = 4;
  localparam int FLD_DONE     = 1;
  localparam int FLD_RUNNING  = 0;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // Arbitration sample points
  localparam logic [8:0] ARB_SAMPLE_DIV4 = 9'h038;
  localparam logic [8:0] ARB_SAMPLE_PRES = 9'h008;
  // Timing
  localparam int BUS_DIV   = 4;
  localparam int BAUD_DIV  = 16;
  localparam int OVERSAMPLE = 16;
  typedef enum logic [1:0]
  {
    AM_IDLE    = 2'b00,
    AM_MEASURE = 2'b01,
    AM_ARB     = 2'b10,
    AM_RSVD    = 2'b11
  } arb_mode_t;
  typedef enum logic [1:0]
  {
    TX_IDLE  = 2'b00,
    TX_PRE   = 2'b01,
    TX_DATA  = 2'b10,
    TX_BREAK = 2'b11
  } tx_state_t;
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : serial_pkg

// File: serial_rx_arbiter.sv
// Purpose: serial transmit idle/inversion, receiver and bus arbiter
// Assumes: rx pin asynchronous; registers on a plain strobe port
// Notes:   one clock, slower rates are enable pulses
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_arbiter
  import serial_pkg::*;
#(
  parameter int BAUD_DIVIDE = BAUD_DIV
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            rx_irq
);
  reg_req_t   req;
  logic       rx_meta_reg;
  logic       rx_sync_reg;
  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic [7:0] data_reg;
  logic       ninth_reg;
  logic       full_reg;
  logic       frame_reg;
  logic       noise_reg;
  logic       break_reg;
  logic       busy_reg;
  logic [7:0] rdata_reg;
  logic [1:0] am_reg;
  logic       aclk_reg;
  logic       lost_reg;
  logic       done_reg;
  logic       run_reg;
  logic [9:0] acnt_reg;
  logic       seen_low_reg;
  logic       txd_prev_reg;
  logic [1:0] div4_reg;
  logic [7:0] pres_reg;
  logic       half_reg;
  logic [3:0] rsub_reg;
  logic [3:0] rbit_reg;
  logic [9:0] rshift_reg;
  logic       rx_prev_reg;
  logic       meas_prev_reg;
  tx_state_t  tx_state_reg;
  logic [3:0] tbit_reg;
  logic [3:0] tsub_reg;
  logic [8:0] tshift_reg;
  logic       tx_en_prev_reg;
  logic       idle_queued_reg;
  logic       txd_reg;
  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
  // Decode
  wire wr_ctl1 = req.wr && req.addr == OFF_CONTROL_ONE;
  wire wr_ctl2 = req.wr && req.addr == OFF_CONTROL_TWO;
  wire wr_st1  = req.wr && req.addr == OFF_STATUS_ONE;
  wire wr_st2  = req.wr && req.addr == OFF_STATUS_TWO;
  wire wr_arb  = req.wr && req.addr == OFF_ARB_CTL;
  wire rd_data = req.rd && req.addr == OFF_DATA;
  wire nine    = ctl1_reg[FLD_NINE_BIT];
  wire tx_en   = ctl2_reg[FLD_TX_EN];
  wire rx_en   = ctl2_reg[FLD_RX_EN];
  // Enables: prescaler gives 16x baud ticks
  wire pres_tick = pres_reg == 8'(BAUD_DIVIDE - 1);
  wire div4_tick = div4_reg == 2'(BUS_DIV - 1);
  wire acnt_tick = aclk_reg ? (pres_tick && half_reg) : div4_tick;
  wire rx        = rx_sync_reg;
  // Receiver
  wire [3:0] rx_len   = nine ? 4'hA : 4'h9;
  wire       rx_start = rx_en && !busy_reg && !rx && rx_prev_reg && pres_tick;
  wire       rx_mid   = busy_reg && pres_tick && rsub_reg == 4'(OVERSAMPLE / 2 - 1);
  wire       rx_last  = rx_mid && rbit_reg == rx_len;
  wire [9:0] rx_word  = {rx, rshift_reg[9:1]};
  wire [8:0] rx_data  = nine ? rx_word[8:0] : {rx_word[8], rx_word[8:1]};
  wire       rx_brk   = rx_last && rx_word == 10'h000 && !rx;
  wire       rx_ferr  = rx_last && !rx;
  // Arbiter
  wire txd_rise   = txd_reg && !txd_prev_reg;
  wire arb_mode   = am_reg == AM_ARB;
  wire meas_mode  = am_reg == AM_MEASURE;
  wire [8:0] samp = aclk_reg ? ARB_SAMPLE_PRES : ARB_SAMPLE_DIV4;
  wire arb_sample = arb_mode && run_reg && acnt_tick && acnt_reg[8:0] == samp;
  wire arb_reset  = arb_mode && !txd_reg && !seen_low_reg && !lost_reg;
  wire meas_edge  = meas_mode && (rx != meas_prev_reg);
  wire [1:0] am_next = wdata[FLD_AM_HIGH:FLD_AM_LOW];
  // Transmitter bit level before inversion
  wire tx_last = pres_tick && tsub_reg == 4'(OVERSAMPLE - 1)
                 && tbit_reg == (nine ? 4'hA : 4'h9);
  wire tx_raw  = (tx_state_reg == TX_DATA) ? tshift_reg[0]
               : (tx_state_reg == TX_BREAK) ? 1'b0 : 1'b1;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  // Dividers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div4_reg <= 2'h0;
      pres_reg <= 8'h00;
      half_reg <= 1'b0;
    end
    else
    begin
      div4_reg <= div4_reg + 2'h1;
      pres_reg <= pres_tick ? 8'h00 : pres_reg + 8'h01;
      if (pres_tick)
        half_reg <= !half_reg;
    end
  end
  // Control registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl1_reg <= RST_CONTROL;
      ctl2_reg <= RST_CONTROL;
    end
    else
    begin
      if (wr_ctl1)
        ctl1_reg <= wdata;
      if (wr_ctl2)
        ctl2_reg <= wdata;
    end
  end
  // Receive shifter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_reg    <= 1'b0;
      rsub_reg    <= 4'h0;
      rbit_reg    <= 4'h0;
      rshift_reg  <= 10'h000;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      if (pres_tick)
        rx_prev_reg <= rx;
      if (rx_start)
      begin
        busy_reg <= 1'b1;
        rsub_reg <= 4'h0;
        rbit_reg <= 4'h0;
      end
      else if (busy_reg && pres_tick)
      begin
        rsub_reg <= rsub_reg + 4'h1;
        if (rx_mid)
        begin
          rshift_reg <= rx_word;
          rbit_reg   <= rbit_reg + 4'h1;
          if (rx_last)
            busy_reg <= 1'b0;
        end
      end
    end
  end
  // Receive data and flags; set wins over clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_reg  <= 8'h00;
      ninth_reg <= 1'b0;
      full_reg  <= 1'b0;
      frame_reg <= 1'b0;
      noise_reg <= 1'b0;
      break_reg <= 1'b0;
    end
    else
    begin
      if (rx_brk)
      begin
        data_reg  <= 8'h00;
        ninth_reg <= 1'b0;
      end
      else if (rx_last)
      begin
        data_reg  <= rx_data[7:0];
        ninth_reg <= nine ? rx_data[8] : rx_data[7];
      end
      if (wr_st1 && wdata[FLD_RX_FULL])
        full_reg <= 1'b0;
      if (rd_data)
        full_reg <= 1'b0;
      if (rx_last)
        full_reg <= 1'b1;
      if (wr_st1 && wdata[FLD_FRAMING])
        frame_reg <= 1'b0;
      if (rx_ferr)
        frame_reg <= 1'b1;
      if (wr_st1 && wdata[FLD_NOISE])
        noise_reg <= 1'b0;
      if (rx_mid && rx != rx_prev_reg && rbit_reg == 4'h0)
        noise_reg <= 1'b1;
      if (wr_st2 && wdata[FLD_BREAK])
        break_reg <= 1'b0;
      if (rx_brk)
        break_reg <= 1'b1;
    end
  end
  // Transmitter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state_reg    <= TX_IDLE;
      tbit_reg        <= 4'h0;
      tsub_reg        <= 4'h0;
      tshift_reg      <= 9'h1FF;
      tx_en_prev_reg  <= 1'b0;
      idle_queued_reg <= 1'b0;
      txd_reg         <= 1'b1;
    end
    else
    begin
      tx_en_prev_reg <= tx_en;
      txd_reg        <= tx_raw;
      if (tx_en && !tx_en_prev_reg && tx_state_reg != TX_IDLE)
        idle_queued_reg <= 1'b1;
      if (pres_tick && tx_state_reg != TX_IDLE)
        tsub_reg <= tsub_reg + 4'h1;
      if (pres_tick && tsub_reg == 4'(OVERSAMPLE - 1) && tx_state_reg == TX_DATA)
        tshift_reg <= {1'b1, tshift_reg[8:1]};
      if (pres_tick && tsub_reg == 4'(OVERSAMPLE - 1))
        tbit_reg <= tbit_reg + 4'h1;
      unique case (tx_state_reg)
        TX_IDLE:
          if (tx_en && !tx_en_prev_reg)
          begin
            tx_state_reg <= TX_PRE;
            tbit_reg     <= 4'h0;
            tsub_reg     <= 4'h0;
          end
        TX_PRE, TX_DATA, TX_BREAK:
          if (tx_last)
          begin
            tbit_reg <= 4'h0;
            if (idle_queued_reg)
            begin
              tx_state_reg    <= TX_PRE;
              idle_queued_reg <= 1'b0;
            end
            else if (!tx_en)
              tx_state_reg <= TX_IDLE;
            else if (ctl2_reg[FLD_SEND_BRK])
              tx_state_reg <= TX_BREAK;
            else
            begin
              tx_state_reg <= TX_DATA;
              tshift_reg   <= 9'h0FE;
            end
          end
      endcase
    end
  end
  // Arbiter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      am_reg        <= AM_IDLE;
      aclk_reg      <= 1'b0;
      lost_reg      <= 1'b0;
      done_reg      <= 1'b0;
      run_reg       <= 1'b0;
      acnt_reg      <= 10'h000;
      seen_low_reg  <= 1'b0;
      txd_prev_reg  <= 1'b1;
      meas_prev_reg <= 1'b1;
    end
    else
    begin
      txd_prev_reg  <= txd_reg;
      meas_prev_reg <= rx;
      if (wr_arb)
      begin
        am_reg   <= am_next;
        aclk_reg <= wdata[FLD_ACLK];
        done_reg <= 1'b0;
        if (!wdata[FLD_AM_HIGH])
          lost_reg <= 1'b0;
      end
      if (am_reg == AM_IDLE || am_reg == AM_RSVD)
      begin
        acnt_reg     <= 10'h000;
        run_reg      <= 1'b0;
        seen_low_reg <= 1'b0;
      end
      else if (arb_mode && txd_rise && !lost_reg)
      begin
        acnt_reg     <= 10'h000;
        run_reg      <= 1'b1;
        seen_low_reg <= 1'b0;
      end
      else if (arb_reset && run_reg)
      begin
        acnt_reg <= 10'h000;
        run_reg  <= 1'b0;
      end
      else if (meas_edge)
      begin
        if (run_reg)
        begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end
        else if (!done_reg)
        begin
          acnt_reg <= 10'h000;
          run_reg  <= 1'b1;
        end
      end
      else if (run_reg && acnt_tick && !acnt_reg[9])
        acnt_reg <= acnt_reg + 10'h001;
      if (arb_mode && !rx)
        seen_low_reg <= 1'b1;
      if (arb_sample && !rx)
        lost_reg <= 1'b1;
    end
  end
  // Read data one cycle after strobe
  wire [7:0] st1_val = {2'b00, full_reg, 2'b00, noise_reg, frame_reg, 1'b0};
  wire [7:0] st2_val = {6'h00, break_reg, busy_reg};
  wire [7:0] arb_val = {am_reg, lost_reg, aclk_reg, 1'b0, acnt_reg[9],
                        done_reg, run_reg};
  wire [7:0] rd_mux  =
      (req.addr == OFF_STATUS_ONE)  ? st1_val
    : (req.addr == OFF_STATUS_TWO)  ? st2_val
    : (req.addr == OFF_CONTROL_ONE) ? ctl1_reg
    : (req.addr == OFF_CONTROL_TWO) ? ctl2_reg
    : (req.addr == OFF_CONTROL_THR) ? {ninth_reg, 7'h00}
    : (req.addr == OFF_DATA)        ? data_reg
    : (req.addr == OFF_ARB_CTL)     ? arb_val
    : acnt_reg[7:0];
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= req.rd ? rd_mux : 8'h00;
  end
  assign rdata  = rdata_reg;
  assign tx_pin = lost_reg ? 1'b1 : (txd_reg ^ ctl1_reg[FLD_TX_INV]);
  assign rx_irq = full_reg && ctl2_reg[FLD_RX_IE];
endmodule : serial_rx_arbiter
`default_nettype wire

// File: serial_rx_arbiter_asserts.sv
// Purpose: port assertions for serial_rx_arbiter
// Assumes: control bits change only by register writes
// Notes:   bound to the design below
`timescale 1ns/1ps
`default_nettype none
module serial_rx_arbiter_asserts
  import serial_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rx_pin,
  input wire logic       tx_pin,
  input wire logic       rx_irq
);
  logic        ie_reg;
  logic        inv_reg;
  logic        tx_en_reg;
  logic        amh_reg;
  logic [11:0] quiet_reg;
  wire         wr_arb = wr && addr == OFF_ARB_CTL;
  wire         wr_c1  = wr && addr == OFF_CONTROL_ONE;
  wire         wr_c2  = wr && addr == OFF_CONTROL_TWO;
  // Written control bits and idle time
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {ie_reg, inv_reg, tx_en_reg, amh_reg} <= 4'h0;
      quiet_reg <= 12'h000;
    end
    else
    begin
      if (wr_c1) inv_reg <= wdata[FLD_TX_INV];
      if (wr_c2)
        {ie_reg, tx_en_reg} <= {wdata[FLD_RX_IE], wdata[FLD_TX_EN] | wdata[FLD_SEND_BRK]};
      if (wr_arb) amh_reg <= wdata[FLD_AM_HIGH];
      if (tx_en_reg || amh_reg) quiet_reg <= 12'h000;
      else if (quiet_reg != 12'hFA0) quiet_reg <= quiet_reg + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_arb_rd; rd && addr == OFF_ARB_CTL; endsequence
  sequence s_cnt_rd; rd && addr == OFF_ARB_CNT; endsequence
  sequence s_wr_low; wr_arb && !wdata[FLD_AM_HIGH]; endsequence
  sequence s_wr_idle; wr_arb && wdata[7:6] == AM_IDLE; endsequence
  property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stuck");
  property p_irq_en; rx_irq |-> ie_reg; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while masked");
  property p_idle; quiet_reg == 12'hFA0 |-> tx_pin == !inv_reg; endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_lost_hi; s_arb_rd ##1 rdata[FLD_LOST] |-> tx_pin; endproperty
  a_lost_hi: assert property (p_lost_hi) else $error("tx not forced");
  property p_lost_clr; s_wr_low ##2 s_arb_rd |=> !rdata[FLD_LOST]; endproperty
  a_lost_clr: assert property (p_lost_clr) else $error("lost not cleared");
  property p_done_clr; wr_arb ##2 s_arb_rd |=> !rdata[FLD_DONE]; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_stop; s_wr_idle ##2 s_arb_rd |=> !rdata[FLD_RUNNING]; endproperty
  a_stop: assert property (p_stop) else $error("counter runs in idle");
  property p_cnt_rst; s_wr_idle ##2 s_cnt_rd |=> rdata == 8'h00; endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("counter not reset");
endmodule : serial_rx_arbiter_asserts
bind serial_rx_arbiter serial_rx_arbiter_asserts serial_rx_arbiter_asserts_inst (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_irq(rx_irq)
);
`default_nettype wire

// File: serial_line_node.sv
// Purpose: far node on the shared serial line
// Assumes: wired-and line with pull-up
// Notes:   released line reads high
`timescale 1ns/1ps
`default_nettype none
module serial_line_node
  import serial_pkg::*;
#(
  parameter int BIT_CLKS = BAUD_DIV * OVERSAMPLE
)
(
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic drive_reg = 1'b1;
  // Low wins on the shared line
  assign rx_line = drive_reg & tx_line;
  task automatic set_level(input logic lvl);
    drive_reg <= lvl;
  endtask : set_level
  task automatic hold(input logic lvl, input int bits);
    drive_reg <= lvl;
    repeat (bits * BIT_CLKS) @(posedge clk);
  endtask : hold
  task automatic send_char(input logic [8:0] val, input int nbits);
    hold(1'b0, 1);
    for (int i = 0; i < nbits; i++)
      hold(val[i], 1);
    hold(1'b1, 1);
  endtask : send_char
endmodule : serial_line_node
`default_nettype wire

// File: serial_rx_arbiter_tb_top.sv
// Purpose: self-checking bench for serial_rx_arbiter
// Assumes: default baud divide; far node shares the line
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module serial_rx_arbiter_tb_top
  import serial_pkg::*;
;
  localparam int BIT_CLKS = BAUD_DIV * OVERSAMPLE;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rx_pin;
  logic       tx_pin;
  logic       rx_irq;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  serial_rx_arbiter #(.BAUD_DIVIDE(BAUD_DIV)) serial_rx_arbiter_inst (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_irq(rx_irq)
  );
  serial_line_node #(.BIT_CLKS(BIT_CLKS)) serial_line_node_inst (
    .clk(clk), .tx_line(tx_pin), .rx_line(rx_pin)
  );
  always #2.5 clk = ~clk;
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : reg_rd
  task automatic chk(input logic [2:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string s);
    logic [7:0] d;
    reg_rd(a, d);
    cmp(s, e, d & m);
  endtask : chk
  task automatic count_low(input int n, output int low);
    low = 0;
    repeat (n)
    begin
      @(posedge clk);
      low += int'(tx_pin !== 1'b1);
    end
  endtask : count_low
  task automatic t_receive();
    logic [8:0] v [3] = '{9'h0A5, 9'h05A, 9'h15A};
    logic       nine [3] = '{1'b0, 1'b0, 1'b1};
    int         i;
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(OFF_CONTROL_ONE, {3'h0, nine[k], 4'h0});
      reg_wr(OFF_CONTROL_TWO, (k == 0) ? 8'h04 : 8'h24);
      serial_line_node_inst.send_char(v[k], nine[k] ? 9 : 8);
      for (i = 0; i < 2 * BIT_CLKS && rx_irq !== 1'b1; i++)
        @(posedge clk);
      cmp("irq", {7'h00, k != 0}, {7'h00, rx_irq});
      chk(OFF_STATUS_ONE, 8'h20, 8'h20, "full");
      chk(OFF_STATUS_ONE, 8'h20, 8'h20, "full held");
      chk(OFF_DATA, 8'hFF, v[k][7:0], "data");
      chk(OFF_CONTROL_THR, 8'h80, {nine[k] ? v[k][8] : v[k][7], 7'h00}, "ninth");
      cmp("irq off", 8'h00, {7'h00, rx_irq});
      reg_wr(OFF_CONTROL_TWO, 8'h00);
    end
  endtask : t_receive
  task automatic t_break();
    reg_wr(OFF_CONTROL_TWO, 8'h04);
    serial_line_node_inst.hold(1'b0, 12);
    serial_line_node_inst.hold(1'b1, 2);
    chk(OFF_STATUS_ONE, 8'h22, 8'h22, "brk status");
    chk(OFF_STATUS_TWO, 8'h02, 8'h02, "brk flag");
    chk(OFF_CONTROL_THR, 8'h80, 8'h00, "brk ninth");
    reg_wr(OFF_DATA, 8'hFF);
    chk(OFF_DATA, 8'hFF, 8'h00, "brk data");
    reg_wr(OFF_STATUS_ONE, 8'h22);
    reg_wr(OFF_STATUS_TWO, 8'h02);
    chk(OFF_STATUS_ONE, 8'h22, 8'h00, "flags cleared");
    reg_wr(OFF_CONTROL_TWO, 8'h00);
  endtask : t_break
  task automatic t_transmit();
    int n;
    int low;
    reg_wr(OFF_CONTROL_ONE, 8'h20);
    @(posedge clk);
    cmp("inverted idle", 8'h00, {7'h00, tx_pin});
    reg_wr(OFF_CONTROL_ONE, 8'h00);
    @(posedge clk);
    cmp("idle", 8'h01, {7'h00, tx_pin});
    reg_wr(OFF_CONTROL_TWO, 8'h08);
    n = 0;
    while (tx_pin === 1'b1 && n < 12 * BIT_CLKS)
    begin
      @(posedge clk);
      n++;
    end
    cmp("preamble", 8'h01, {7'h00, n > 10 * BIT_CLKS - 64 && n < 10 * BIT_CLKS + 64});
    reg_wr(OFF_CONTROL_TWO, 8'h00);
    count_low(22 * BIT_CLKS, low);
    cmp("finish char", 8'h01, {7'h00, low > 2 * BIT_CLKS - 16 && low < 2 * BIT_CLKS + 16});
  endtask : t_transmit
  task automatic t_requeue();
    int n;
    reg_wr(OFF_CONTROL_TWO, 8'h08);
    n = 0;
    while (tx_pin === 1'b1 && n < 12 * BIT_CLKS)
    begin
      @(posedge clk);
      n++;
    end
    reg_wr(OFF_CONTROL_TWO, 8'h00);
    reg_wr(OFF_CONTROL_TWO, 8'h08);
    repeat (9 * BIT_CLKS + 64) @(posedge clk);
    n = 0;
    while (tx_pin === 1'b1 && n < 12 * BIT_CLKS)
    begin
      @(posedge clk);
      n++;
    end
    cmp("queued idle", 8'h01, {7'h00, n > 9 * BIT_CLKS && n < 12 * BIT_CLKS});
    reg_wr(OFF_CONTROL_TWO, 8'h00);
    repeat (11 * BIT_CLKS) @(posedge clk);
    cmp("idle after", 8'h01, {7'h00, tx_pin});
  endtask : t_requeue
  task automatic t_arbitrate();
    logic [7:0] d;
    int         low;
    reg_wr(OFF_ARB_CTL, 8'h80);
    reg_wr(OFF_CONTROL_TWO, 8'h08);
    serial_line_node_inst.set_level(1'b0);
    d = 8'h00;
    for (int i = 0; i < 2000 && d[FLD_LOST] !== 1'b1; i++)
      reg_rd(OFF_ARB_CTL, d);
    cmp("lost", 8'h20, d & 8'h20);
    count_low(3 * BIT_CLKS, low);
    cmp("forced high", 8'h01, {7'h00, low == 0});
    serial_line_node_inst.set_level(1'b1);
    reg_wr(OFF_CONTROL_TWO, 8'h00);
    reg_wr(OFF_ARB_CTL, 8'h20);
    chk(OFF_ARB_CTL, 8'h21, 8'h00, "lost cleared");
  endtask : t_arbitrate
  task automatic t_measure();
    logic [7:0] d;
    reg_wr(OFF_ARB_CTL, 8'h40);
    serial_line_node_inst.set_level(1'b0);
    repeat (40) @(posedge clk);
    chk(OFF_ARB_CTL, 8'h03, 8'h01, "running");
    serial_line_node_inst.set_level(1'b1);
    repeat (40) @(posedge clk);
    chk(OFF_ARB_CTL, 8'h03, 8'h02, "done");
    reg_rd(OFF_ARB_CNT, d);
    cmp("quarter count", 8'h01, {7'h00, d >= 8'h08 && d <= 8'h0E});
    reg_wr(OFF_ARB_CTL, 8'h40);
    chk(OFF_ARB_CTL, 8'h02, 8'h00, "done cleared");
    reg_wr(OFF_ARB_CTL, 8'h00);
    chk(OFF_ARB_CNT, 8'hFF, 8'h00, "count reset");
  endtask : t_measure
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_receive();
    t_break();
    t_transmit();
    t_requeue();
    t_arbitrate();
    t_measure();
    final_report();
  end
endmodule : serial_rx_arbiter_tb_top
`default_nettype wire
